// File: logic/swid_pkg.sv
// Constants for the single-wire identification bus master
package swid_pkg;
  // Overview of operation
  // - CRC-8 polynomial x8+x5+x4+1, XOR feedback
  // - CRC starts zero, LSB first over 56
  // - Master checks code: CRC over 64 gives zero
  // - Master leaves line high when idle
  // - Master falling edge starts every slot
  // - Standard speed at most 16.3 kbps
  // - Transaction starts with reset and presence
  // - Master sends one 8-bit ROM command
  // - Read only with a single slave
  // - Search bit: true, complement, master write
  // - Both reads zero means branch point
  // - One code per pass, reset each pass
  // - Reset pulse low at least 480 us
  // - Write zero low 60-120, one 1-15 us
  localparam int CLK_MHZ = 250;
  localparam int RESET_LOW_US = 480;
  localparam int RESET_HIGH_US = 480;
  localparam int PRESENCE_SAMPLE_US = 70;
  localparam int SLOT_US = 70;
  localparam int WRITE_ZERO_LOW_US = 65;
  localparam int WRITE_ONE_LOW_US = 6;
  localparam int READ_LOW_US = 6;
  localparam int READ_SAMPLE_US = 13;
  localparam int RECOVERY_US = 5;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int RESET_HIGH_CYC = RESET_HIGH_US * CLK_MHZ;
  localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
  localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
  localparam int WRITE_ZERO_LOW_CYC = WRITE_ZERO_LOW_US * CLK_MHZ;
  localparam int WRITE_ONE_LOW_CYC = WRITE_ONE_LOW_US * CLK_MHZ;
  localparam int READ_LOW_CYC = READ_LOW_US * CLK_MHZ;
  localparam int READ_SAMPLE_CYC = READ_SAMPLE_US * CLK_MHZ;
  localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  localparam logic [7:0] CMD_READ = 8'h33;
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam int CODE_BITS = 64;
  localparam int CMD_BITS = 8;
  typedef enum logic [1:0] {SWID_OP_RESET, SWID_OP_READ, SWID_OP_SEARCH} swid_op_t;
endpackage : swid_pkg

// File: logic/swid_master.sv
// Bus master that resets, reads and searches single-wire identification devices
`timescale 1ns/1ns
module swid_master
  import swid_pkg::*;
#(
  parameter int RESET_LOW = RESET_LOW_CYC,
  parameter int RESET_HIGH = RESET_HIGH_CYC,
  parameter int PRES_SAMPLE = PRESENCE_SAMPLE_CYC,
  parameter int SLOT = SLOT_CYC,
  parameter int W0_LOW = WRITE_ZERO_LOW_CYC,
  parameter int W1_LOW = WRITE_ONE_LOW_CYC,
  parameter int R_LOW = READ_LOW_CYC,
  parameter int R_SAMPLE = READ_SAMPLE_CYC,
  parameter int RECOVERY = RECOVERY_CYC
)
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [63:0] i_search_path,
  input wire logic i_line,
  output logic o_line_oe,
  output logic o_line_out,
  output logic o_busy,
  output logic o_done,
  output logic o_presence,
  output logic [63:0] o_code,
  output logic o_crc_ok,
  output logic [63:0] o_branch_zero
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_RST_HIGH,
    ST_CMD, ST_READ, ST_SRCH_T, ST_SRCH_C, ST_SRCH_W, ST_FINISH
  } swid_state_t;

  typedef enum logic [1:0] {SL_WRITE, SL_READ} swid_slot_t;

  function automatic logic [7:0] swid_crc_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    swid_crc_step = (crc >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
  endfunction : swid_crc_step

  swid_state_t state_q;
  logic line_s1_q;
  logic line_s2_q;
  logic [31:0] cnt_q;
  logic slot_act_q;
  swid_slot_t slot_kind_q;
  logic slot_bit_q;
  logic slot_rx_q;
  logic slot_done_q;
  logic [6:0] idx_q;
  logic [7:0] cmd_q;
  logic [1:0] op_q;
  logic [63:0] path_q;
  logic bit_t_q;
  logic [7:0] crc_q;

  // Two-flop synchroniser on the line
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end
    else
    begin
      line_s1_q <= i_line;
      line_s2_q <= line_s1_q;
    end
  end

  // Slot engine: falling edge, hold low, sample, recover
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 32'h0000_0000;
      o_line_oe <= 1'b0;
      o_line_out <= 1'b0;
      slot_done_q <= 1'b0;
      slot_rx_q <= 1'b1;
    end
    else
    begin
      slot_done_q <= 1'b0;
      if (slot_act_q)
      begin
        cnt_q <= cnt_q + 32'h0000_0001;
        // Count 0 is a spare cycle so a finishing sequencer stops before a new edge
        if (cnt_q == 32'h0000_0001)
          o_line_oe <= 1'b1;
        if (slot_kind_q == SL_WRITE)
        begin
          if (cnt_q == 32'(slot_bit_q ? W1_LOW : W0_LOW))
            o_line_oe <= 1'b0;
        end
        else
        begin
          if (cnt_q == 32'(R_LOW))
            o_line_oe <= 1'b0;
          if (cnt_q == 32'(R_SAMPLE))
            slot_rx_q <= line_s2_q;
        end
        if (cnt_q == 32'(SLOT + RECOVERY))
        begin
          cnt_q <= 32'h0000_0000;
          slot_done_q <= 1'b1;
        end
      end
      else if (state_q == ST_RST_LOW || state_q == ST_RST_WAIT || state_q == ST_RST_HIGH)
      begin
        o_line_oe <= (state_q == ST_RST_LOW) && (cnt_q < 32'(RESET_LOW));
        cnt_q <= (state_q == ST_RST_WAIT) ? cnt_q : cnt_q + 32'h0000_0001;
        if (state_q == ST_RST_LOW && cnt_q == 32'(RESET_LOW + PRES_SAMPLE))
          cnt_q <= 32'h0000_0000;
        if (state_q == ST_RST_HIGH && cnt_q == 32'(RESET_HIGH))
          cnt_q <= 32'h0000_0000;
      end
      else
      begin
        cnt_q <= 32'h0000_0000;
        o_line_oe <= 1'b0;
      end
    end
  end

  // Transaction sequencer
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_IDLE;
      slot_act_q <= 1'b0;
      slot_kind_q <= SL_WRITE;
      slot_bit_q <= 1'b1;
      idx_q <= 7'h00;
      cmd_q <= 8'h00;
      op_q <= 2'h0;
      path_q <= 64'h0000_0000_0000_0000;
      bit_t_q <= 1'b0;
      crc_q <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_presence <= 1'b0;
      o_code <= 64'h0000_0000_0000_0000;
      o_crc_ok <= 1'b0;
      o_branch_zero <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      o_done <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (i_start)
          begin
            op_q <= i_op;
            path_q <= i_search_path;
            cmd_q <= (i_op == 2'(SWID_OP_SEARCH)) ? CMD_SEARCH : CMD_READ;
            o_busy <= 1'b1;
            o_presence <= 1'b0;
            o_crc_ok <= 1'b0;
            state_q <= ST_RST_LOW;
          end
        end
        ST_RST_LOW:
        begin
          if (cnt_q == 32'(RESET_LOW + PRES_SAMPLE))
          begin
            o_presence <= ~line_s2_q;
            state_q <= ST_RST_HIGH;
          end
        end
        ST_RST_WAIT:
          state_q <= ST_RST_HIGH;
        ST_RST_HIGH:
        begin
          if (cnt_q == 32'(RESET_HIGH))
          begin
            idx_q <= 7'h00;
            crc_q <= 8'h00;
            if (!o_presence || op_q == 2'(SWID_OP_RESET))
              state_q <= ST_FINISH;
            else
            begin
              state_q <= ST_CMD;
              slot_act_q <= 1'b1;
              slot_kind_q <= SL_WRITE;
              slot_bit_q <= cmd_q[0];
            end
          end
        end
        ST_CMD:
        begin
          if (slot_done_q)
          begin
            idx_q <= idx_q + 7'h01;
            slot_bit_q <= cmd_q[3'(idx_q + 7'h01)];
            if (idx_q == 7'(CMD_BITS - 1))
            begin
              idx_q <= 7'h00;
              slot_kind_q <= SL_READ;
              state_q <= (op_q == 2'(SWID_OP_SEARCH)) ? ST_SRCH_T : ST_READ;
            end
          end
        end
        ST_READ:
        begin
          if (slot_done_q)
          begin
            o_code[6'(idx_q)] <= slot_rx_q;
            crc_q <= swid_crc_step(crc_q, slot_rx_q);
            idx_q <= idx_q + 7'h01;
            if (idx_q == 7'(CODE_BITS - 1))
            begin
              slot_act_q <= 1'b0;
              state_q <= ST_FINISH;
            end
          end
        end
        ST_SRCH_T:
        begin
          if (slot_done_q)
          begin
            bit_t_q <= slot_rx_q;
            state_q <= ST_SRCH_C;
          end
        end
        ST_SRCH_C:
        begin
          if (slot_done_q)
          begin
            o_branch_zero[6'(idx_q)] <= ~bit_t_q & ~slot_rx_q;
            slot_kind_q <= SL_WRITE;
            if (!bit_t_q && !slot_rx_q)
              slot_bit_q <= path_q[6'(idx_q)];
            else
              slot_bit_q <= bit_t_q;
            state_q <= ST_SRCH_W;
          end
        end
        ST_SRCH_W:
        begin
          if (slot_done_q)
          begin
            o_code[6'(idx_q)] <= slot_bit_q;
            crc_q <= swid_crc_step(crc_q, slot_bit_q);
            slot_kind_q <= SL_READ;
            idx_q <= idx_q + 7'h01;
            state_q <= (idx_q == 7'(CODE_BITS - 1)) ? ST_FINISH : ST_SRCH_T;
            if (idx_q == 7'(CODE_BITS - 1))
              slot_act_q <= 1'b0;
          end
        end
        ST_FINISH:
        begin
          slot_act_q <= 1'b0;
          o_crc_ok <= o_presence && (op_q != 2'(SWID_OP_RESET)) && (crc_q == 8'h00);
          o_busy <= 1'b0;
          o_done <= 1'b1;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule : swid_master

// File: tb/swid_master_checker.sv
// Line and handshake assertions for the identification bus master
`timescale 1ns/1ns
module swid_master_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic o_line_oe,
  input wire logic o_line_out,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_presence,
  input wire logic o_crc_ok
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_drain; !o_line_out; endproperty
  a_drain: assert property (p_drain) else $error("line driven high");
  property p_reset_low; $rose(o_busy) |=> o_line_oe [*8]; endproperty
  a_reset_low: assert property (p_reset_low) else $error("no reset pulse");
  property p_idle; !o_busy |-> !o_line_oe; endproperty
  a_idle: assert property (p_idle) else $error("line low while idle");
  property p_take; i_start && !o_busy |=> o_busy; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_done; o_done |-> $past(o_busy) && !o_busy ##1 !o_done; endproperty
  a_done: assert property (p_done) else $error("bad done pulse");
  property p_recover; $fell(o_line_oe) |-> !o_line_oe [*4]; endproperty
  a_recover: assert property (p_recover) else $error("short recovery");
  property p_low_min; $rose(o_line_oe) |-> o_line_oe [*4]; endproperty
  a_low_min: assert property (p_low_min) else $error("short low pulse");
  property p_crc_pres; o_done && o_crc_ok |-> o_presence; endproperty
  a_crc_pres: assert property (p_crc_pres) else $error("crc ok without presence");
  property p_busy_end; $fell(o_busy) |-> o_done; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
endmodule : swid_master_checker

bind swid_master swid_master_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_start(i_start), .o_line_oe(o_line_oe), .o_line_out(o_line_out), .o_busy(o_busy),
  .o_done(o_done), .o_presence(o_presence), .o_crc_ok(o_crc_ok));

// File: tb/swid_dev_model.sv
// Behavioural identification device on the shared line
`timescale 1ns/1ns
module swid_dev_model (
  input wire logic i_clock,
  input wire logic i_on,
  input wire logic [63:0] i_code,
  input wire logic i_line,
  output logic o_pull
);
  int low = 0, t = 99, n = 0, pres = -1, mode = 0, ph = 0;
  logic prev = 1, snd = 0, d = 0;
  logic [7:0] cmd = 0;
  always @(posedge i_clock)
  begin
    low = (i_line === 1'b0) ? low + 1 : 0;
    if (low > 100)
    begin
      mode = 1;
      n = 0;
      ph = 0;
      pres = 0;
    end
    if (pres >= 0 && (i_line || pres > 0))
      pres = pres + 1;
    if (pres == 95)
      pres = -1;
    t = (prev && !i_line && pres < 0) ? 0 : t + 1;
    prev = i_line;
    if (t == 0)
    begin
      snd = mode == 2 || (mode == 3 && ph < 2);
      d = i_code[n] ^ (ph == 1);
    end
    if (t == 30 && mode != 0)
    begin
      if (mode == 1)
        cmd = {i_line, cmd[7:1]};
      if (mode == 3 && ph == 2 && i_line != i_code[n])
        mode = 0;
      if (mode == 3)
        ph = (ph == 2) ? 0 : ph + 1;
      if (mode != 0 && ph == 0)
        n = n + 1;
      if (mode == 1 && n == 8)
      begin
        mode = (cmd == 8'h33 || cmd == 8'h0F) ? 2 : (cmd == 8'hF0 ? 3 : 0);
        n = 0;
      end
      if (n == 64)
        mode = 0;
    end
    o_pull <= i_on && ((pres > 15 && pres < 95) || (snd && !d && t < 20));
  end
endmodule : swid_dev_model

// File: tb/swid_master_tb_top.sv
// Self-checking bench for the identification bus master
`timescale 1ns/1ns
module swid_master_tb_top;
  import swid_pkg::*;
  typedef struct {logic p; logic [63:0] c; logic k; logic [63:0] b; int f;} swid_exp_t;
  logic i_clock = 0, i_rst_n = 0, i_start = 0, on_a = 0, on_b = 0;
  logic [1:0] i_op = 0;
  logic [63:0] i_search_path = 0, code_a = 0, code_b = 0, o_code, o_branch_zero, rp;
  localparam int T_RST = 200, T_PRES = 60, T_SLOT = 80, T_W0 = 60, T_SHORT = 6;
  localparam int T_RSMP = 14, T_REC = 5;
  logic o_line_oe, o_line_out, o_busy, o_done, o_presence, o_crc_ok, pull_a, pull_b;
  wire line = !(o_line_oe | pull_a | pull_b);
  int fail_count = 0, samples_checked = 0, cyc = 0;
  swid_exp_t exp_q[$];
  swid_exp_t x;
  always #2 i_clock = ~i_clock;
  swid_master #(.RESET_LOW(T_RST), .RESET_HIGH(T_RST), .PRES_SAMPLE(T_PRES), .SLOT(T_SLOT),
    .W0_LOW(T_W0), .W1_LOW(T_SHORT), .R_LOW(T_SHORT), .R_SAMPLE(T_RSMP),
    .RECOVERY(T_REC)) dut (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op), .i_search_path(i_search_path),
    .i_line(line), .o_line_oe(o_line_oe), .o_line_out(o_line_out), .o_busy(o_busy),
    .o_done(o_done), .o_presence(o_presence), .o_code(o_code), .o_crc_ok(o_crc_ok),
    .o_branch_zero(o_branch_zero));
  swid_dev_model dev_a (.i_clock(i_clock), .i_on(on_a), .i_code(code_a), .i_line(line),
    .o_pull(pull_a));
  swid_dev_model dev_b (.i_clock(i_clock), .i_on(on_b), .i_code(code_b), .i_line(line),
    .o_pull(pull_b));
  function automatic logic [63:0] with_crc(input logic [55:0] v);
    logic [7:0] c;
    c = 0;
    for (int i = 0; i < 56; i++)
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
    return {c, v};
  endfunction : with_crc
  function automatic swid_exp_t srch(input logic [63:0] p);
    int k;
    k = 0;
    while (code_a[k] == code_b[k])
      k++;
    return '{1, (p[k] == code_a[k]) ? code_a : code_b, 1, 64'h1 << k, 3};
  endfunction : srch
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input logic [1:0] op, input logic [63:0] path, input swid_exp_t e);
    exp_q.push_back(e);
    i_op <= op;
    i_search_path <= path;
    i_start <= 1;
    @(posedge i_clock);
    i_start <= 0;
    @(posedge i_clock);
    while (o_busy === 1'b1)
      @(posedge i_clock);
    $display("test op %0d finished at %0t", op, $time);
  endtask : run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clock)
  begin
    cyc++;
    if (o_done === 1'b1)
    begin
      x = exp_q.pop_front();
      chk(64'(o_presence), 64'(x.p));
      if (x.f > 0)
        chk(64'(o_crc_ok), 64'(x.k));
      if (x.f > 1)
        chk(o_code, x.c);
      if (x.f > 2)
        chk(o_branch_zero, x.b);
    end
    if (cyc == 80000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(13));
    code_a = with_crc({16'($urandom), 32'($urandom), 8'h2D});
    code_b = with_crc({16'($urandom), 32'($urandom), 8'h2D});
    rp = {$urandom, $urandom};
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1;
    run(2'd1, 0, '{0, 0, 0, 0, 1});
    on_a <= 1;
    run(2'd0, 0, '{1, 0, 0, 0, 0});
    run(2'd1, 0, '{1, code_a, 1, 0, 2});
    run(2'd3, 0, '{1, code_a, 1, 0, 2});
    on_b <= 1;
    run(2'd2, rp, srch(rp));
    run(2'd2, ~rp, srch(~rp));
    on_b <= 0;
    code_a <= code_a ^ (64'h1 << 63);
    run(2'd1, 0, '{1, code_a ^ (64'h1 << 63), 0, 0, 2});
    report_and_stop();
  end
endmodule : swid_master_tb_top
